// *** core/radio_spi_pkg.sv ***
// Constants and types shared by the radio serial configuration port
package radio_spi_pkg;

  localparam int          CFG_COUNT      = 47;
  localparam logic [5:0]  CFG_LAST_ADDR  = 6'h2e;
  localparam logic [5:0]  STROBE_FIRST   = 6'h30;
  localparam logic [5:0]  STROBE_LAST    = 6'h3d;
  localparam logic [5:0]  TX_FIFO_ADDR   = 6'h3f;
  localparam logic [5:0]  ADDR_STEP      = 6'h01;

  // Read-only status registers in the strobe range, selected with the burst flag set
  localparam logic [5:0]  STAT_RADIO_STATE_ADDR = 6'h35;
  localparam logic [5:0]  STAT_TX_BYTES_ADDR    = 6'h3a;

  // Header byte layout
  localparam int          HDR_RW_BIT     = 7;
  localparam int          HDR_BURST_BIT  = 6;
  localparam int          HDR_ADDR_MSB   = 5;

  // Status byte layout
  localparam int          STAT_RDY_BIT   = 7;
  localparam int          STAT_STATE_MSB = 6;
  localparam int          STAT_STATE_LSB = 4;
  localparam int          STAT_FREE_MSB  = 3;
  localparam logic [3:0]  FREE_MAX       = 4'hf;
  localparam logic [6:0]  TX_FIFO_DEPTH  = 7'h40;

  localparam logic [2:0]  LAST_BIT       = 3'h7;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  ZERO_BYTE      = 8'h00;

  // Command strobe addresses
  localparam logic [5:0]  CMD_CHIP_RESET  = 6'h30;
  localparam logic [5:0]  CMD_CRYSTAL_OFF = 6'h32;
  localparam logic [5:0]  CMD_GO_IDLE     = 6'h36;
  localparam logic [5:0]  CMD_POWER_DOWN  = 6'h39;
  localparam logic [5:0]  CMD_FLUSH_TX    = 6'h3b;

  // Main radio state codes as reported in the status byte
  typedef enum logic [2:0] {
    ST_IDLE      = 3'h0,
    ST_TX        = 3'h2,
    ST_FAST_TX   = 3'h3,
    ST_CALIBRATE = 3'h4,
    ST_SETTLING  = 3'h5,
    ST_UNDERFLOW = 3'h7
  } main_state_t;

endpackage

// *** core/radio_spi_status_strobe_port.sv ***
// Serial slave port: status byte, register access, status reads and command strobes
// Summary of operation
// - Status byte returned on header, write data, strobe
// - Bit 7 low only when crystal, supply ready
// - Bits 6:4 report the main radio state
// - Transitional states may report idle code
// - Bits 3:0 free transmit bytes, saturating 15
// - Configuration registers 0x00-0x2E read and write
// - Writes return status per byte, reads data
// - Burst address counter increments every byte, holds at 0x3F
// - Burst flag picks status register over strobe
// - Go-idle cancels other strobes until idle
// - Power-down, crystal-off act at select release
// - Idle keeps only crystal and core powered
// - Underflow held until flush strobe acknowledges
// - Every transaction starts with header byte
// - All bits shifted most significant first
// - Select high abandons the transfer in progress
`timescale 1ns/100ps
module radio_spi_status_strobe_port
  import radio_spi_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   sclk,
  input  wire logic                   chip_select_n,
  input  wire logic                   si,
  output logic                        so,
  output logic                        so_oe,
  input  wire logic                   crystal_stable,
  input  wire logic                   supply_stable,
  input  main_state_t                 main_state,
  input  wire logic                   state_transitional,
  input  wire logic [6:0]             tx_fill,
  output logic [CFG_COUNT*8-1:0]      cfg_regs,
  output logic                        strobe_valid,
  output logic [5:0]                  strobe_code,
  output logic                        fifo_wr,
  output logic [7:0]                  fifo_data,
  output logic                        crystal_oscillator_en,
  output logic                        analog_power_en
);

  // Link-side frame state, cleared whenever the select is released
  typedef struct packed {
    logic        started;
    logic        data_phase;
    logic [2:0]  bitcnt;
    logic [6:0]  rx;
    logic [7:0]  tx;
    logic        rd;
    logic        burst;
    logic        stat_sel;
    logic [5:0]  addr;
  } link_t;

  // Link-side events toward the system clock, held across frames
  typedef struct packed {
    logic        wr_tgl;
    logic [5:0]  wr_addr;
    logic [7:0]  wr_data;
    logic        st_tgl;
    logic [5:0]  st_code;
  } event_t;

  typedef struct packed {
    logic [1:0]             xtal_sync;
    logic [1:0]             supply_sync;
    logic [1:0]             cs_sync;
    logic [2:0]             wr_sync;
    logic [2:0]             st_sync;
    logic [CFG_COUNT-1:0][7:0] cfg;
    logic [7:0]             status;
    logic                   idle_pend;
    logic                   pend_pwd;
    logic                   pend_xoff;
    logic                   osc_en;
    logic                   power_en;
    logic                   strobe_valid;
    logic [5:0]             strobe_code;
    logic                   fifo_wr;
    logic [7:0]             fifo_data;
  } sys_t;

  link_t  lk_r;
  link_t  lk_nxt;
  event_t ev_r;
  event_t ev_nxt;
  sys_t   sy_r;
  sys_t   sy_nxt;

  function automatic logic in_strobe_range(input logic [5:0] a);
    return (a >= STROBE_FIRST) && (a <= STROBE_LAST);
  endfunction

  function automatic logic [2:0] state_code(input main_state_t s, input logic trans);
    if (trans && ((s == ST_CALIBRATE) || (s == ST_SETTLING))) begin
      return ST_IDLE;
    end
    return s;
  endfunction

  function automatic logic [3:0] free_sat(input logic [6:0] fill);
    logic [6:0] free;
    free = TX_FIFO_DEPTH - fill;
    return (free > {3'h0, FREE_MAX}) ? FREE_MAX : free[3:0];
  endfunction

  // Register contents seen by the link; the array only changes on writes and the chip-reset strobe from this same link,
  // and status fields move under the radio, so a read may catch a field mid-update
  function automatic logic [7:0] rd_byte(input logic [5:0] a, input logic stat);
    if (stat) begin
      if (a == STAT_RADIO_STATE_ADDR) begin
        return {5'h00, state_code(main_state, state_transitional)};
      end
      if (a == STAT_TX_BYTES_ADDR) begin
        return {1'b0, tx_fill};
      end
      return ZERO_BYTE;
    end
    if (a <= CFG_LAST_ADDR) begin
      return sy_r.cfg[a];
    end
    return ZERO_BYTE;
  endfunction

  // Link logic
  always_comb begin
    logic [7:0] byte_in;
    logic [5:0] a;
    logic       strobe_hit;
    byte_in    = {lk_r.rx, si};
    a          = byte_in[HDR_ADDR_MSB:0];
    strobe_hit = in_strobe_range(a);
    lk_nxt     = lk_r;
    ev_nxt     = ev_r;
    lk_nxt.started = 1'b1;
    lk_nxt.rx      = byte_in[6:0];
    lk_nxt.bitcnt  = lk_r.bitcnt + 3'h1;
    lk_nxt.tx      = {lk_r.tx[6:0], 1'b0};
    if (!lk_r.started) begin
      lk_nxt.tx = {sy_r.status[6:0], 1'b0};
    end
    if (lk_r.bitcnt == LAST_BIT) begin
      lk_nxt.tx = sy_r.status;
      if (!lk_r.data_phase) begin
        // Header byte decode
        lk_nxt.rd       = byte_in[HDR_RW_BIT];
        lk_nxt.burst    = byte_in[HDR_BURST_BIT];
        lk_nxt.addr     = a;
        lk_nxt.stat_sel = strobe_hit && byte_in[HDR_BURST_BIT];
        if (strobe_hit && !byte_in[HDR_BURST_BIT]) begin
          ev_nxt.st_tgl  = ~ev_r.st_tgl;
          ev_nxt.st_code = a;
        end else begin
          lk_nxt.data_phase = 1'b1;
          if (byte_in[HDR_RW_BIT]) begin
            lk_nxt.tx = rd_byte(a, strobe_hit);
          end
        end
      end else begin
        if (!lk_r.rd) begin
          ev_nxt.wr_tgl  = ~ev_r.wr_tgl;
          ev_nxt.wr_addr = lk_r.addr;
          ev_nxt.wr_data = byte_in;
        end
        if (lk_r.burst && !lk_r.stat_sel) begin
          if (lk_r.addr != TX_FIFO_ADDR) begin
            lk_nxt.addr = lk_r.addr + ADDR_STEP;
          end
          if (lk_r.rd) begin
            lk_nxt.tx = rd_byte(lk_r.addr + ADDR_STEP, 1'b0);
          end
        end else begin
          lk_nxt.data_phase = 1'b0;
        end
      end
    end
  end

  // Select high clears the frame at once, wherever the byte stood
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      ev_r <= '0;
    end else begin
      ev_r <= ev_nxt;
    end
  end

  // Before the first edge the ready flag goes straight out
  always_comb begin
    so_oe = ~chip_select_n;
    if (chip_select_n) begin
      so = 1'b0;
    end else if (!lk_r.started) begin
      so = sy_r.status[STAT_RDY_BIT];
    end else begin
      so = lk_r.tx[7];
    end
  end

  // System-side logic
  always_comb begin
    logic       wr_ev;
    logic       st_ev;
    logic       issue;
    logic [5:0] code;
    logic       cs_high;
    sy_nxt   = sy_r;
    wr_ev    = sy_r.wr_sync[1] ^ sy_r.wr_sync[2];
    st_ev    = sy_r.st_sync[1] ^ sy_r.st_sync[2];
    cs_high  = sy_r.cs_sync[1];
    code     = ev_r.st_code;
    issue    = 1'b0;
    sy_nxt.xtal_sync   = {sy_r.xtal_sync[0], crystal_stable};
    sy_nxt.supply_sync = {sy_r.supply_sync[0], supply_stable};
    sy_nxt.cs_sync  = {sy_r.cs_sync[0], chip_select_n};
    sy_nxt.wr_sync  = {sy_r.wr_sync[1:0], ev_r.wr_tgl};
    sy_nxt.st_sync  = {sy_r.st_sync[1:0], ev_r.st_tgl};
    sy_nxt.strobe_valid = 1'b0;
    sy_nxt.fifo_wr      = 1'b0;
    sy_nxt.status[STAT_RDY_BIT] = ~(sy_r.xtal_sync[1] & sy_r.supply_sync[1] & sy_r.osc_en);
    sy_nxt.status[STAT_STATE_MSB:STAT_STATE_LSB] = state_code(main_state, state_transitional);
    sy_nxt.status[STAT_FREE_MSB:0] = free_sat(tx_fill);
    sy_nxt.power_en = (main_state != ST_IDLE);
    if (main_state == ST_IDLE) begin
      sy_nxt.idle_pend = 1'b0;
    end
    if (wr_ev) begin
      if (ev_r.wr_addr <= CFG_LAST_ADDR) begin
        sy_nxt.cfg[ev_r.wr_addr] = ev_r.wr_data;
      end else if (ev_r.wr_addr == TX_FIFO_ADDR) begin
        sy_nxt.fifo_wr   = 1'b1;
        sy_nxt.fifo_data = ev_r.wr_data;
      end
    end
    if (st_ev && (!sy_r.idle_pend || (code == CMD_GO_IDLE))) begin
      unique case (code)
        CMD_POWER_DOWN:  sy_nxt.pend_pwd  = 1'b1;
        CMD_CRYSTAL_OFF: sy_nxt.pend_xoff = 1'b1;
        CMD_GO_IDLE: begin
          issue = 1'b1;
          sy_nxt.pend_pwd  = 1'b0;
          sy_nxt.pend_xoff = 1'b0;
          sy_nxt.idle_pend = (main_state != ST_IDLE);
        end
        CMD_FLUSH_TX: begin
          issue = (main_state == ST_IDLE) || (main_state == ST_UNDERFLOW);
        end
        CMD_CHIP_RESET: begin
          issue = 1'b1;
          for (int i = 0; i < CFG_COUNT; i++) begin
            sy_nxt.cfg[i] = CFG_RESET;
          end
        end
        default: issue = 1'b1;
      endcase
    end else if (cs_high && sy_r.pend_pwd) begin
      issue            = 1'b1;
      code             = CMD_POWER_DOWN;
      sy_nxt.pend_pwd  = 1'b0;
      sy_nxt.osc_en    = 1'b0;
    end else if (cs_high && sy_r.pend_xoff) begin
      issue            = 1'b1;
      code             = CMD_CRYSTAL_OFF;
      sy_nxt.pend_xoff = 1'b0;
      sy_nxt.osc_en    = 1'b0;
    end else if (!cs_high && !sy_r.osc_en) begin
      sy_nxt.osc_en = 1'b1;
    end
    if (issue) begin
      sy_nxt.strobe_valid = 1'b1;
      sy_nxt.strobe_code  = code;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      sy_r         <= '0;
      sy_r.cs_sync <= 2'h3;
      sy_r.osc_en  <= 1'b1;
      sy_r.status  <= 8'h80;
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign cfg_regs              = sy_r.cfg;
  assign strobe_valid          = sy_r.strobe_valid;
  assign strobe_code           = sy_r.strobe_code;
  assign fifo_wr               = sy_r.fifo_wr;
  assign fifo_data             = sy_r.fifo_data;
  assign crystal_oscillator_en = sy_r.osc_en;
  assign analog_power_en       = sy_r.power_en;

endmodule

// *** bench/radio_spi_properties.sv ***
// Concurrent checks on the pins of the radio serial port
`timescale 1ns/100ps
module radio_spi_properties
  import radio_spi_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        sclk,
  input wire logic        chip_select_n,
  input wire logic        so,
  input wire logic        so_oe,
  input wire logic        crystal_stable,
  input wire logic        supply_stable,
  input main_state_t      main_state,
  input wire logic        strobe_valid,
  input wire logic [5:0]  strobe_code,
  input wire logic        fifo_wr,
  input wire logic        crystal_oscillator_en,
  input wire logic        analog_power_en
);
  logic rdy;
  logic seen_r;
  assign rdy = crystal_stable & supply_stable;
  // Set once the frame has had its first serial clock edge
  always_ff @(posedge sclk or posedge chip_select_n) begin
    if (chip_select_n)
      seen_r <= 1'b0;
    else
      seen_r <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  property p_oe;
    so_oe == !chip_select_n;
  endproperty
  a_oe: assert property (p_oe) else $error("so_oe does not follow select");
  property p_so_idle;
    chip_select_n |-> !so;
  endproperty
  a_so_idle: assert property (p_so_idle) else $error("so driven while deselected");
  property p_not_ready;
    !chip_select_n && !seen_r && !rdy && !$past(rdy, 5) |-> so;
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("ready shown too early");
  property p_ready;
    !chip_select_n && !seen_r && rdy && $past(rdy, 5) && $past(nrst, 5) &&
      crystal_oscillator_en && $past(crystal_oscillator_en) |-> !so;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown");
  property p_strobe_range;
    strobe_valid |-> strobe_code inside {[STROBE_FIRST:STROBE_LAST]};
  endproperty
  a_strobe_range: assert property (p_strobe_range) else $error("strobe outside range");
  property p_strobe_once;
    strobe_valid |=> !strobe_valid;
  endproperty
  a_strobe_once: assert property (p_strobe_once) else $error("strobe pulse too long");
  property p_fifo_once;
    fifo_wr |=> !fifo_wr;
  endproperty
  a_fifo_once: assert property (p_fifo_once) else $error("fifo write pulse too long");
  property p_osc_off;
    $fell(crystal_oscillator_en) |-> chip_select_n && $past(chip_select_n, 2);
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("crystal off before release");
  property p_analog;
    $past(nrst) |-> analog_power_en == ($past(main_state) != ST_IDLE);
  endproperty
  a_analog: assert property (p_analog) else $error("analog power wrong");
endmodule

// *** bench/radio_host_model.sv ***
// Behavioural host that masters the serial port with a 30 ns bit period
`timescale 1ns/100ps
module radio_host_model (
  output logic       sclk,
  output logic       chip_select_n,
  output logic       si,
  input  wire logic  so
);
  initial begin
    sclk = 1'b0;
    chip_select_n = 1'b1;
    si = 1'b0;
  end
  task automatic open_frame(input bit wait_rdy, output bit ok);
    int n;
    n = 0;
    chip_select_n = 1'b0;
    #20;
    while (wait_rdy && so !== 1'b0 && n < 200) begin
      #10;
      n++;
    end
    ok = !wait_rdy || so === 1'b0;
  endtask
  // Header first, then data, msb first; si moves at the falling edge
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    for (int i = 7; i > 7 - nbits; i--) begin
      si = tx[i];
      #15;
      rx[i] = so;
      sclk = 1'b1;
      #15;
      sclk = 1'b0;
    end
  endtask
  task automatic close_frame;
    #20;
    chip_select_n = 1'b1;
    si = ~si;
    #60;
  endtask
endmodule

// *** bench/test_radio_spi_status_strobe_port.sv ***
// Self-checking bench for the radio serial status and strobe port
`timescale 1ns/100ps
module test_radio_spi_status_strobe_port;
  import radio_spi_pkg::*;
  logic                   clk_sys, nrst, sclk, chip_select_n, si, so, so_oe, xtal, supply, trans;
  logic                   strobe_valid, fifo_wr, osc_en, analog_en;
  main_state_t            main_state;
  logic [6:0]             tx_fill;
  logic [5:0]             strobe_code, last_code;
  logic [7:0]             fifo_data, last_fifo;
  logic [7:0]             r [4];
  logic [CFG_COUNT*8-1:0] cfg_regs;
  int                     bad_count, cmp_count, n_strobe, n_fifo;
  bit                     ok;
  logic [2:0]             codes [7] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h7, 3'h4};
  logic [6:0]             fills [7] = '{7'd64, 7'd49, 7'd50, 7'd63, 7'd0, 7'd60, 7'd2};

  radio_spi_status_strobe_port i_dut (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .chip_select_n(chip_select_n),
    .si(si), .so(so), .so_oe(so_oe), .crystal_stable(xtal), .supply_stable(supply), .main_state(main_state),
    .state_transitional(trans), .tx_fill(tx_fill), .cfg_regs(cfg_regs), .strobe_valid(strobe_valid),
    .strobe_code(strobe_code), .fifo_wr(fifo_wr), .fifo_data(fifo_data), .crystal_oscillator_en(osc_en),
    .analog_power_en(analog_en));
  radio_host_model i_host (.sclk(sclk), .chip_select_n(chip_select_n), .si(si), .so(so));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (strobe_valid === 1'b1) begin
      n_strobe <= n_strobe + 1;
      last_code <= strobe_code;
    end
    if (fifo_wr === 1'b1) begin
      n_fifo <= n_fifo + 1;
      last_fifo <= fifo_data;
    end
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [7:0] stat(input logic [2:0] code, input logic [6:0] fill);
    logic [6:0] free;
    free = TX_FIFO_DEPTH - fill;
    return {1'b0, code, (free > 7'd15) ? FREE_MAX : free[3:0]};
  endfunction
  task automatic open_f;
    i_host.open_frame(1'b1, ok);
    if (!ok) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  // Sends n bytes from the top of b in one frame, answers land in r
  task automatic frame(input logic [31:0] b, input int n);
    open_f();
    for (int k = 0; k < n; k++)
      i_host.shift(b[31-8*k -: 8], 8, r[k]);
    i_host.close_frame();
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic set_state(input logic [2:0] code, input logic [6:0] fill);
    @(posedge clk_sys);
    main_state <= main_state_t'(code);
    tx_fill <= fill;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic t_not_ready;
    i_host.open_frame(1'b0, ok);
    repeat (10) @(posedge clk_sys);
    check("not ready", 8'h01, {7'h0, so});
    xtal <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("ready", 8'h00, {7'h0, so});
    supply <= 1'b0;
    repeat (8) @(posedge clk_sys);
    check("supply not ready", 8'h01, {7'h0, so});
    supply <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check("supply ready", 8'h00, {7'h0, so});
    i_host.close_frame();
  endtask
  task automatic t_states;
    for (int i = 0; i < 7; i++) begin
      trans <= (i == 6);
      set_state(codes[i], fills[i]);
      frame({2'b11, STAT_RADIO_STATE_ADDR, 24'h0}, 2);
      check("status", stat((i == 6) ? 3'h0 : codes[i], fills[i]), r[0]);
      if (i < 6)
        check("state reg", {5'h0, codes[i]}, r[1]);
    end
    trans <= 1'b0;
    set_state(3'h0, 7'd60);
  endtask
  task automatic t_regs;
    frame({2'b00, CFG_LAST_ADDR, 8'ha5, 16'h0}, 2);
    check("write hdr status", 8'h04, r[0]);
    check("write data status", 8'h04, r[1]);
    check("cfg last", 8'ha5, cfg_regs[8*46 +: 8]);
    frame({2'b10, CFG_LAST_ADDR, 24'h0}, 2);
    check("read hdr status", 8'h04, r[0]);
    check("read data", 8'ha5, r[1]);
    frame(32'h40112233, 4);
    for (int k = 1; k < 4; k++)
      check("burst status", 8'h04, r[k]);
    check("cfg burst 0", 8'h11, cfg_regs[7:0]);
    check("cfg burst 1", 8'h22, cfg_regs[15:8]);
    check("cfg burst", 8'h33, cfg_regs[23:16]);
    frame(32'hc1000000, 3);
    check("burst read 1", 8'h22, r[1]);
    check("burst read", 8'h33, r[2]);
    open_f();
    i_host.shift(8'h01, 8, r[0]);
    i_host.shift(8'hff, 4, r[1]);
    i_host.close_frame();
    repeat (10) @(posedge clk_sys);
    check("abort", 8'h22, cfg_regs[15:8]);
    frame(32'h3f5a0000, 2);
    check("fifo", 8'h5a, last_fifo);
    check("fifo count", 8'h01, 8'(n_fifo));
  endtask
  task automatic t_strobes;
    int n0;
    set_state(3'h2, 7'd60);
    n0 = n_strobe;
    frame({2'b00, CMD_GO_IDLE, 24'h0}, 1);
    check("strobe status", 8'h24, r[0]);
    frame({2'b00, STROBE_LAST, 24'h0}, 1);
    check("pending", 8'(n0 + 1), 8'(n_strobe));
    set_state(3'h0, 7'd60);
    frame({2'b00, STROBE_LAST, 24'h0}, 1);
    check("after idle", {2'b0, STROBE_LAST}, {2'b0, last_code});
    set_state(3'h2, 7'd60);
    n0 = n_strobe;
    frame({2'b00, CMD_FLUSH_TX, 24'h0}, 1);
    check("flush refused", 8'(n0), 8'(n_strobe));
    set_state(3'h7, 7'd60);
    frame({2'b00, CMD_FLUSH_TX, 24'h0}, 1);
    check("flush", {2'b0, CMD_FLUSH_TX}, {2'b0, last_code});
    frame({2'b00, CMD_CHIP_RESET, 24'h0}, 1);
    check("chip reset", {2'b0, CMD_CHIP_RESET}, {2'b0, last_code});
    check("cfg cleared", CFG_RESET, cfg_regs[8*46 +: 8]);
    // The next frame opens only once the serial output has gone low
    frame({2'b00, STROBE_LAST, 24'h0}, 1);
    check("after reset", {2'b0, STROBE_LAST}, {2'b0, last_code});
    set_state(3'h0, 7'd60);
  endtask
  task automatic t_deferred(input logic [5:0] cmd);
    int n0;
    n0 = n_strobe;
    open_f();
    i_host.shift({2'b00, cmd}, 8, r[0]);
    repeat (20) @(posedge clk_sys);
    check("deferred", 8'(n0), 8'(n_strobe));
    i_host.close_frame();
    check("acted", {2'b0, cmd}, {2'b0, last_code});
    check("osc off", 8'h00, {7'h0, osc_en});
  endtask
  initial begin
    nrst = 1'b1;
    xtal = 1'b0;
    supply = 1'b1;
    trans = 1'b0;
    main_state = ST_IDLE;
    tx_fill = 7'd60;
    // Reset falls after time zero so the link toggles see a real falling edge
    @(posedge clk_sys);
    nrst <= 1'b0;
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    t_not_ready();
    t_states();
    t_regs();
    t_strobes();
    t_deferred(CMD_POWER_DOWN);
    t_deferred(CMD_CRYSTAL_OFF);
    tally_and_finish();
  end
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule

bind radio_spi_status_strobe_port radio_spi_properties i_props (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk),
  .chip_select_n(chip_select_n), .so(so), .so_oe(so_oe), .crystal_stable(crystal_stable),
  .supply_stable(supply_stable), .main_state(main_state), .strobe_valid(strobe_valid), .strobe_code(strobe_code),
  .fifo_wr(fifo_wr), .crystal_oscillator_en(crystal_oscillator_en), .analog_power_en(analog_power_en));
